// ==== core/ocfg_params.svh ====
// offsets, field positions, reset values and pin codes of the config slice
// assumes byte offsets within a 256-byte config header
`ifndef OCFG_PARAMS_SVH
`define OCFG_PARAMS_SVH

// ----------------------------------------
// register offsets (byte)
// ----------------------------------------
`define OCFG_OFF_CAPPTR 8'h34
`define OCFG_OFF_ROUTE 8'h3c
`define OCFG_OFF_PIN 8'h3d
`define OCFG_OFF_TIMING 8'h3e
`define OCFG_OFF_PM0 8'h44
`define OCFG_OFF_PM1 8'h48

// ----------------------------------------
// values and reset values
// ----------------------------------------
`define OCFG_CAPPTR_VAL 8'h44
`define OCFG_ROUTE_RST 8'h00
`define OCFG_TIMING_RST 16'h0402
`define OCFG_PIN_INTA 8'h01
`define OCFG_PIN_INTB 8'h02
`define OCFG_PIN_INTC 8'h03

// ----------------------------------------
// function numbers and byte lanes
// ----------------------------------------
`define OCFG_FUNC_CARD0 2'h0
`define OCFG_FUNC_CARD1 2'h1
`define OCFG_FUNC_OHCI 2'h2
`define OCFG_LANE_ROUTE 0

`endif

// ==== core/ocfg_pkg.sv ====
// types shared by the config slice and its pin routing helper
// assumes nothing beyond the params header
package ocfg_pkg;

  // one configuration access, taken in a single cycle
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] byteEn;
    logic [31:0] data;
  } ocfg_req_s;

  // answer, one cycle after the access
  typedef struct packed {
    logic ack;
    logic claim;
    logic pmHit;
    logic [31:0] data;
  } ocfg_rsp_s;

  // the three interrupt lines
  typedef struct packed {
    logic intA;
    logic intB;
    logic intC;
  } ocfg_irq_s;

endpackage : ocfg_pkg

// ==== core/ocfg_pin_route.sv ====
// interrupt pin report and internal interrupt merging
// assumes tie bits come from the system control register on the same clock
`timescale 1ns/10ps
`include "ocfg_params.svh"

module ocfg_pin_route (
  // tie controls and function number
  input wire logic tieAbInterrupts,
  input wire logic tieEveryInterrupt,
  input wire logic [1:0] funcNumber,
  // raw requests
  input wire ocfg_pkg::ocfg_irq_s irqIn,
  // results
  output ocfg_pkg::ocfg_irq_s irqOut,
  output logic [7:0] pinReportValue
);
  import ocfg_pkg::*;

  // report table per function and tie setting
  function automatic logic [7:0] pinOf(input logic [1:0] fn, input logic ab, input logic all);
    logic [7:0] v;
    v = `OCFG_PIN_INTA;
    if (all) begin
      v = `OCFG_PIN_INTA;
    end else if (fn == `OCFG_FUNC_CARD1) begin
      v = ab ? `OCFG_PIN_INTA : `OCFG_PIN_INTB;
    end else if (fn == `OCFG_FUNC_OHCI) begin
      v = `OCFG_PIN_INTC;
    end
    return v;
  endfunction : pinOf

  // readback follows the live tie bits so software sees the real wiring
  assign pinReportValue = pinOf(funcNumber, tieAbInterrupts, tieEveryInterrupt);

  // merging: tie-all folds all onto INTA, A/B tie folds B onto A
  wire mergeB = tieAbInterrupts | tieEveryInterrupt;
  wire mergeC = tieEveryInterrupt;
  assign irqOut.intA = irqIn.intA | (mergeB & irqIn.intB) | (mergeC & irqIn.intC);
  assign irqOut.intB = irqIn.intB & ~mergeB;
  assign irqOut.intC = irqIn.intC & ~mergeC;

endmodule : ocfg_pin_route

// ==== core/ocfg_irq_latency_regs.sv ====
// config header slice: cap pointer, interrupt line/pin, grant/latency
// assumes a config access port on the local clock, an external EEPROM
// loader, and the tie bits from the system control register
//
// Summary of operation
// - cap pointer reads constant 44h
// - PM registers sit at 44h and 48h
// - interrupt routing byte is writable, resets zero
// - pin report derived from two tie bits
// - pin codes per function and tie setting
// - A/B tie merges card B onto INTA
// - EEPROM present: grant/latency loaded after reset
// - no EEPROM: grant/latency reads 0402h
// - latency high byte, grant low, read-only
// - grant/latency returned to 0402h only by global reset
`timescale 1ns/10ps
`include "ocfg_params.svh"

module ocfg_irq_latency_regs (
  // clock and global reset
  input wire logic clock,
  input wire logic rst,
  // ordinary bus reset pin, active low, asynchronous to clock
  input wire logic pciRst_n,
  // configuration access
  input wire ocfg_pkg::ocfg_req_s cfgReq,
  output ocfg_pkg::ocfg_rsp_s cfgRsp,
  // tie bits and function identity
  input wire logic tieAbInterrupts,
  input wire logic tieEveryInterrupt,
  input wire logic [1:0] funcNumber,
  // EEPROM loader
  input wire logic eepromPresent,
  input wire logic eepromLoadValid,
  input wire logic [15:0] eepromLoadData,
  // interrupt requests in and routed out
  input wire ocfg_pkg::ocfg_irq_s irqIn,
  output ocfg_pkg::ocfg_irq_s irqOut,
  // stored values to the rest of the function
  output logic [7:0] irqRouteField,
  output logic [15:0] busTimingRequest
);
  import ocfg_pkg::*;

  // ----------------------------------------
  // decoding
  // ----------------------------------------
  function automatic logic dwHit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction : dwHit

  wire hitCap = dwHit(cfgReq.addr, `OCFG_OFF_CAPPTR);
  wire hitIrq = dwHit(cfgReq.addr, `OCFG_OFF_ROUTE);
  wire hitPm = dwHit(cfgReq.addr, `OCFG_OFF_PM0) | dwHit(cfgReq.addr, `OCFG_OFF_PM1);
  wire rdCap = cfgReq.valid & ~cfgReq.write & hitCap;
  wire rdIrq = cfgReq.valid & ~cfgReq.write & hitIrq;
  wire wrRoute = cfgReq.valid & cfgReq.write & hitIrq & cfgReq.byteEn[`OCFG_LANE_ROUTE];

  // ----------------------------------------
  // bus reset synchroniser
  // ----------------------------------------
  logic [2:0] pciSync_r;
  logic pciRstActive_r;
  logic pciRstActive_nxt;

  // a change counts once stages two and three agree
  assign pciRstActive_nxt = (pciSync_r[2:1] == 2'b00) ? 1'b1 :
                            (pciSync_r[2:1] == 2'b11) ? 1'b0 : pciRstActive_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pciSync_r <= 3'h0;
      pciRstActive_r <= 1'b1;
    end else begin
      pciSync_r <= {pciSync_r[1:0], pciRst_n};
      pciRstActive_r <= pciRstActive_nxt;
    end
  end

  // ----------------------------------------
  // pin report and interrupt merging
  // ----------------------------------------
  logic [7:0] pinReportValue;
  ocfg_irq_s irqRouted;

  ocfg_pin_route uPinRoute (
    .tieAbInterrupts(tieAbInterrupts),
    .tieEveryInterrupt(tieEveryInterrupt),
    .funcNumber(funcNumber),
    .irqIn(irqIn),
    .irqOut(irqRouted),
    .pinReportValue(pinReportValue)
  );

  // ----------------------------------------
  // interrupt routing byte
  // ----------------------------------------
  logic [7:0] route_nxt;
  // bus reset also clears it; the clear beats a same-cycle write
  assign route_nxt = pciRstActive_r ? `OCFG_ROUTE_RST :
                     wrRoute ? cfgReq.data[7:0] : irqRouteField;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irqRouteField <= `OCFG_ROUTE_RST;
    end else begin
      irqRouteField <= route_nxt;
    end
  end

  // ----------------------------------------
  // grant/latency, global reset only
  // ----------------------------------------
  logic loadArmed_r;
  // only the first load after reset lands, so a stray strobe cannot change it
  wire loadFire = loadArmed_r & eepromPresent & eepromLoadValid;

  // bus reset is deliberately not in this process
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busTimingRequest <= `OCFG_TIMING_RST;
      loadArmed_r <= 1'b1;
    end else if (loadFire) begin
      busTimingRequest <= eepromLoadData;
      loadArmed_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // read data and answer
  // ----------------------------------------
  wire [31:0] irqDword = {busTimingRequest, pinReportValue, irqRouteField};
  wire [31:0] capDword = {24'h0, `OCFG_CAPPTR_VAL};
  wire [31:0] rdData = (hitCap ? capDword : 32'h0) | (hitIrq ? irqDword : 32'h0);
  ocfg_rsp_s rsp_nxt;

  // every access is answered; unclaimed ones read zero, writes to RO drop
  always_comb begin
    rsp_nxt.ack = cfgReq.valid;
    rsp_nxt.claim = cfgReq.valid & (hitCap | hitIrq);
    rsp_nxt.pmHit = cfgReq.valid & hitPm;
    rsp_nxt.data = (cfgReq.valid & ~cfgReq.write) ? rdData : 32'h0;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfgRsp <= '0;
      irqOut <= '0;
    end else begin
      cfgRsp <= rsp_nxt;
      irqOut <= irqRouted;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_access_answered: assert property (cfgReq.valid |=> cfgRsp.ack)
    else $error("access not answered next cycle");
  a_capptr_value: assert property (rdCap |=> cfgRsp.data == 32'h00000044)
    else $error("cap pointer read wrong");
  a_pm_window_hit: assert property (cfgReq.valid && hitPm |=> cfgRsp.pmHit && !cfgRsp.claim)
    else $error("PM window not flagged");
  a_route_write_lands: assert property (wrRoute && !pciRstActive_r |=>
      irqRouteField == $past(cfgReq.data[7:0]))
    else $error("route write lost");
  a_pin_readback: assert property (rdIrq |=> cfgRsp.data[15:8] == $past(pinReportValue))
    else $error("pin report readback wrong");
  a_pin_table_all: assert property (tieEveryInterrupt |-> pinReportValue == 8'h01)
    else $error("tie-all pin not INTA");
  a_pin_table_ohci: assert property (!tieEveryInterrupt && funcNumber == 2'h2 |->
      pinReportValue == 8'h03)
    else $error("OHCI pin not INTC");
  a_ab_merge: assert property (tieAbInterrupts && irqIn.intB |=> irqOut.intA && !irqOut.intB)
    else $error("B not merged onto A");
  a_eeprom_load: assert property (loadFire |=> busTimingRequest == $past(eepromLoadData))
    else $error("EEPROM load lost");
  a_timing_default: assert property (!eepromPresent |-> ##1 $stable(busTimingRequest))
    else $error("timing moved without EEPROM");
  a_timing_ro: assert property (!loadFire |=> $stable(busTimingRequest))
    else $error("timing changed without load");
  a_capptr_ro_write: assert property (cfgReq.valid && cfgReq.write && hitCap |=>
      cfgRsp.claim && $stable(irqRouteField))
    else $error("RO write disturbed state");

  c_route_write: cover property (wrRoute ##1 rdIrq);
  c_eeprom_load: cover property (loadFire);
  c_tie_ab: cover property (tieAbInterrupts && !tieEveryInterrupt && rdIrq);
  c_bus_reset: cover property ($rose(pciRstActive_r));

endmodule : ocfg_irq_latency_regs

// ==== tb/ocfg_host_model.sv ====
// host bridge model issuing single configuration accesses
// assumes the block answers every access within a few cycles
`timescale 1ns/10ps

module ocfg_host_model (
  // clock
  input wire logic clock,
  // config port
  output ocfg_pkg::ocfg_req_s cfgReq,
  input wire ocfg_pkg::ocfg_rsp_s cfgRsp
);
  import ocfg_pkg::*;

  initial cfgReq = '0;

  // request held over one rising edge, then released with inverted fields
  // so a stale value can never pass for a held one; the answer is registered
  // at the taking edge and stands one cycle, so it is looked at from the
  // falling edge that follows, before it is gone
  task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d, output ocfg_rsp_s rsp);
    rsp = '0;
    @(negedge clock);
    cfgReq <= '{valid: 1'b1, write: wr, addr: a, byteEn: be, data: d};
    @(negedge clock);
    cfgReq <= '{valid: 1'b0, write: ~wr, addr: ~a, byteEn: ~be, data: ~d};
    // bounded wait for the one-cycle answer, first look without waiting
    for (int i = 0; i < 4; i++) begin
      if (cfgRsp.ack === 1'b1) begin
        rsp = cfgRsp;
        break;
      end
      @(negedge clock);
    end
  endtask : access
endmodule : ocfg_host_model

// ==== tb/ocfg_tb.sv ====
// self-checking bench for the config header slice
// assumes the host model drives the config port; all else driven here
`timescale 1ns/10ps

module tb;
  import ocfg_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic pciRst_n = 1'b1;
  logic tieAb = 1'b0;
  logic tie_every_interrupt = 1'b0;
  logic [1:0] func = 2'h2;
  logic eePresent = 1'b0;
  logic eeValid = 1'b0;
  logic [15:0] eeData = 16'h0000;
  ocfg_irq_s irqIn = '0;
  ocfg_irq_s irqOut;
  ocfg_req_s cfgReq;
  ocfg_rsp_s cfgRsp;
  ocfg_rsp_s r;
  logic [7:0] routeField;
  logic [15:0] timing;
  int num_errors = 0;
  int cmp_count = 0;

  always #25 clock = ~clock;

  ocfg_host_model host (.clock(clock), .cfgReq(cfgReq), .cfgRsp(cfgRsp));
  ocfg_irq_latency_regs DUT (.clock(clock), .rst(rst), .pciRst_n(pciRst_n),
    .cfgReq(cfgReq), .cfgRsp(cfgRsp), .tieAbInterrupts(tieAb),
    .tieEveryInterrupt(tie_every_interrupt), .funcNumber(func), .eepromPresent(eePresent),
    .eepromLoadValid(eeValid), .eepromLoadData(eeData), .irqIn(irqIn),
    .irqOut(irqOut), .irqRouteField(routeField), .busTimingRequest(timing));

  // ----------------------------------------
  // compare, access, reset and closing helpers
  // ----------------------------------------
  task automatic chk_val(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_bit(string what, logic exp, logic got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic end_sim();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // a missing answer ends the run at once
  task automatic cfg(logic wr, logic [7:0] a, logic [3:0] be, logic [31:0] d);
    host.access(wr, a, be, d, r);
    if (r.ack !== 1'b1) begin
      num_errors++;
      $display("mismatch ack expected 1 seen 0");
      end_sim();
    end
  endtask : cfg

  // extra edges let the bus reset synchroniser settle
  task automatic do_reset();
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
  endtask : do_reset

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    cfg(0, 8'h34, 4'h0, 0);
    chk_bit("claim34", 1'b1, r.claim);
    chk_val("capPtr", 32'h0000_0044, r.data);
    cfg(0, 8'h3c, 4'h0, 0);
    chk_bit("claim3c", 1'b1, r.claim);
    chk_val("dword3c", 32'h0402_0300, r.data);
    chk_val("timingPort", 32'h0402, timing);
  endtask : t_reset_values

  task automatic t_pm_and_unmapped();
    cfg(0, 8'h44, 4'h0, 0);
    chk_bit("pmHit44", 1'b1, r.pmHit);
    cfg(0, 8'h48, 4'h0, 0);
    chk_bit("pmHit48", 1'b1, r.pmHit);
    cfg(0, 8'h40, 4'h0, 0);
    chk_bit("pmHit40", 1'b0, r.pmHit);
    chk_val("data40", 32'h0, {r.data[31:1], r.claim});
  endtask : t_pm_and_unmapped

  // read-only lanes and the pointer must ignore writes
  task automatic t_writes();
    cfg(1, 8'h3c, 4'h1, 32'hffff_ffa5);
    chk_val("routePort", 32'ha5, routeField);
    cfg(1, 8'h3c, 4'he, 32'h5a5a_5a00);
    cfg(1, 8'h34, 4'hf, 32'h0);
    chk_bit("claim34Wr", 1'b1, r.claim);
    chk_val("data34Wr", 32'h0, r.data);
    cfg(0, 8'h3c, 4'h0, 0);
    chk_val("dword3cWr", 32'h0402_03a5, r.data);
    cfg(0, 8'h34, 4'h0, 0);
    chk_val("capPtrWr", 32'h44, r.data);
  endtask : t_writes

  // serialized irq mode is taken as set before any tie bit is raised
  task automatic t_pin_table();
    logic [7:0] exp;
    for (int t = 0; t < 4; t++) begin
      for (int f = 0; f < 3; f++) begin
        {tie_every_interrupt, tieAb} = t[1:0];
        func = f[1:0];
        exp = tie_every_interrupt ? 8'h01 : (f == 2) ? 8'h03 : (f == 1 && !tieAb) ? 8'h02 : 8'h01;
        cfg(0, 8'h3d, 4'h0, 0);
        chk_val("pinReport", exp, r.data[15:8]);
      end
    end
  endtask : t_pin_table

  // each entry: tieAb, tie_every_interrupt, raw requests, expected merged requests
  task automatic t_irq_merge();
    logic [7:0] cases [5] = '{8'b00_010_010, 8'b10_010_100, 8'b10_001_001,
                              8'b01_001_100, 8'b01_011_100};
    foreach (cases[i]) begin
      {tieAb, tie_every_interrupt, irqIn} = cases[i][7:3];
      @(negedge clock);
      chk_val("irqOut", cases[i][2:0], irqOut);
    end
    irqIn = '0;
  endtask : t_irq_merge

  task automatic t_eeprom_reset();
    {eePresent, eeValid, eeData} = {2'b11, 16'h1234};
    @(negedge clock);
    {eeValid, eeData} = {1'b1, 16'h9999};
    chk_val("timingLoad", 32'h1234, timing);
    @(negedge clock);
    eeValid = 1'b0;
    cfg(0, 8'h3c, 4'h0, 0);
    chk_val("timingRead", 32'h1234, r.data[31:16]);
    pciRst_n = 1'b0;
    repeat (5) @(negedge clock);
    // a route write while the bus reset is active must be dropped
    cfg(1, 8'h3c, 4'h1, 32'h77);
    chk_bit("claimBusRstWr", 1'b1, r.claim);
    pciRst_n = 1'b1;
    chk_val("timingBusRst", 32'h1234, timing);
    chk_val("routeBusRst", 32'h0, routeField);
    eePresent = 1'b0;
    do_reset();
    eeValid = 1'b1;
    @(negedge clock);
    eeValid = 1'b0;
    @(negedge clock);
    chk_val("timingNoRom", 32'h0402, timing);
  endtask : t_eeprom_reset

  initial begin
    do_reset();
    t_reset_values();
    t_pm_and_unmapped();
    t_writes();
    t_pin_table();
    t_irq_merge();
    t_eeprom_reset();
    end_sim();
  end
endmodule : tb
